/* File: src/spw_params.svh */
// constants for the serial eeprom page-write and guard block
// assumes a 50 MHz system clock and a host-driven spi link clock
//
// Function
// - one write changes at most 32 bytes, all in one page
// - byte pointer wraps to the page start after the top page byte
// - over 32 data bytes: only the last 32 received are kept
// - array inside the block-guard region is never changed
// - array outside the region changes only while the write latch is 1
// - finishing an array write clears the write latch
// - hardware protection never blocks array writes
// - latch 0 makes array and guard/arm status fields read-only
// - latch 1, protection off: unguarded array and status fields writable
// - latch 1, protection on: unguarded array writable, status fields locked
// - only address bits 12..0 select a byte, bits 15..13 ignored
// - array write opcode is 0000 x010, msb first, x ignored
// - while busy only the status read command is accepted; here every frame is ignored while busy
// - guard code 00 none, 01 1800h-1fffh, 10 1000h-1fffh, 11 everything
`ifndef SPW_PARAMS_SVH
`define SPW_PARAMS_SVH

// ==========================================
// opcodes, compared after masking the x bit
`define SPW_OPC_MASK 8'hf7
`define SPW_OPC_WRITE 8'h02
`define SPW_OPC_SETL 8'h06
`define SPW_OPC_CLRL 8'h04
`define SPW_OPC_STRD 8'h05
`define SPW_OPC_STWR 8'h01

// ==========================================
// array geometry
`define SPW_AW 13
`define SPW_PW 5
`define SPW_PAGE 32
`define SPW_PG_LAST 5'h1f
`define SPW_BITS_LAST 3'h7
`define SPW_GUARD_QTR 13'h1800
`define SPW_GUARD_HALF 13'h1000

// ==========================================
// status byte positions for a status write
`define SPW_SB_ARM 7
`define SPW_SB_BG_HI 3
`define SPW_SB_BG_LO 2

// ==========================================
// timing
`define SPW_T_WC_MS 5
`define SPW_CLK_MHZ 50
`define SPW_WC_CYC (`SPW_T_WC_MS * 1000 * `SPW_CLK_MHZ)
`define SPW_WC_W 18
`define SPW_FIFO_DEPTH 32

`endif

/* File: src/spw_pkg.sv */
// types shared by the page-write block and its fifo
// assumes spw_params.svh is on the include path
`include "spw_params.svh"

package spw_pkg;

  typedef enum logic [3:0] {
    SPW_IDLE, SPW_OPC, SPW_AHI, SPW_ALO, SPW_DATA, SPW_STWR,
    SPW_SKIP, SPW_LOAD, SPW_DRAIN, SPW_WAIT
  } spw_state_t;

  typedef enum logic [1:0] {SPW_C_NONE, SPW_C_SETL, SPW_C_CLRL} spw_cmd_t;

  typedef struct packed {
    logic arm;
    logic [1:0] bg;
    logic latch;
    logic busy;
  } spw_stat_t;

  typedef struct packed {
    logic [`SPW_AW-1:0] addr;
    logic [7:0] data;
  } spw_arr_t;

endpackage

/* File: src/spw_fifo.sv */
// flop-based fifo with valid/ready on both sides
// assumes one clock, asynchronous active-low reset
`timescale 1ns/100ps

module spw_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  logic [AW:0] nxt_wr;
  logic [AW:0] nxt_rd;
  logic full;
  logic empty;
  logic push;

  // ==========================================
  // pointers carry a wrap bit so full and empty are exact
  always_comb
  begin
    empty = (wr_ff == rd_ff);
    full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
    in_ready = ~full;
    out_valid = ~empty;
    out_data = mem_ff[rd_ff[AW-1:0]];
    push = in_valid & ~full;
    nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd = (out_ready & ~empty) ? rd_ff + 1'b1 : rd_ff;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
    end
    else
    begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
  end

  // storage needs no reset; only written words are ever read
  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem_ff[wr_ff[AW-1:0]] <= in_data;
    end
  end

endmodule

/* File: src/spw_top.sv */
// page-write path and write guarding of a serial eeprom device
// assumes spi mode 0/3 on the link pins and a clocked array write port
`timescale 1ns/100ps
`include "spw_params.svh"

module spw_top #(
  parameter int WC_CYC = `SPW_WC_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  input wire logic arr_ready,
  output logic arr_we,
  output spw_pkg::spw_arr_t arr_word,
  output logic ready_n,
  output logic write_latch,
  output logic hw_guard_arm_bit,
  output logic block_guard_bit_hi,
  output logic block_guard_bit_lo
);
  import spw_pkg::*;

  // ==========================================
  // link side, clocked by sck
  logic [2:0] bit_ff;
  logic [6:0] sh_ff;
  logic [7:0] rx_ff;
  logic tgl_ff;
  logic [2:0] nxt_bit;
  logic [6:0] nxt_sh;
  logic [7:0] nxt_rx;
  logic nxt_tgl;
  logic sck_clr_n;

  // frame ends by chip select itself, since sck stops between frames
  assign sck_clr_n = rst_n & ~cs_n;

  always_comb
  begin
    nxt_bit = bit_ff + 1'b1;
    nxt_sh = {sh_ff[5:0], si};
    nxt_rx = rx_ff;
    nxt_tgl = tgl_ff;
    if (bit_ff == `SPW_BITS_LAST)
    begin
      nxt_rx = {sh_ff, si}; // msb first
      nxt_tgl = ~tgl_ff;
    end
  end

  always_ff @(posedge sck or negedge sck_clr_n)
  begin
    if (!sck_clr_n)
    begin
      bit_ff <= '0;
      sh_ff <= '0;
    end
    else
    begin
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
    end
  end

  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_ff <= '0;
      tgl_ff <= 1'b0;
    end
    else
    begin
      rx_ff <= nxt_rx;
      tgl_ff <= nxt_tgl;
    end
  end

  // ==========================================
  // crossings into clk_sys
  // rx_ff holds for eight sck periods, far longer than the toggle sync
  logic cs_s1_ff, cs_s2_ff, cs_s3_ff, cs_s4_ff;
  logic tg_s1_ff, tg_s2_ff, tg_s3_ff;
  logic wp_s1_ff, wp_s2_ff;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {cs_s1_ff, cs_s2_ff, cs_s3_ff, cs_s4_ff} <= 4'hf;
      {tg_s1_ff, tg_s2_ff, tg_s3_ff} <= 3'h0;
      {wp_s1_ff, wp_s2_ff} <= 2'h3;
    end
    else
    begin
      {cs_s1_ff, cs_s2_ff, cs_s3_ff, cs_s4_ff} <=
        {cs_n, cs_s1_ff, cs_s2_ff, cs_s3_ff};
      {tg_s1_ff, tg_s2_ff, tg_s3_ff} <= {tgl_ff, tg_s1_ff, tg_s2_ff};
      {wp_s1_ff, wp_s2_ff} <= {wp_n, wp_s1_ff};
    end
  end

  logic byte_evt;
  logic frm_start;
  logic frm_end;
  logic hw_prot;

  // end is seen one cycle after a coincident last byte, never before it
  assign byte_evt = tg_s2_ff ^ tg_s3_ff;
  assign frm_start = cs_s3_ff & ~cs_s2_ff;
  assign frm_end = cs_s3_ff & ~cs_s4_ff;

  // ==========================================
  // helpers
  function automatic logic in_guard(input logic [1:0] bg,
                                    input logic [`SPW_AW-1:0] a);
    case (bg)
      2'b00: in_guard = 1'b0;
      2'b01: in_guard = (a >= `SPW_GUARD_QTR);
      2'b10: in_guard = (a >= `SPW_GUARD_HALF);
      default: in_guard = 1'b1;
    endcase
  endfunction

  function automatic logic is_opc(input logic [7:0] b, input logic [7:0] o);
    is_opc = ((b & `SPW_OPC_MASK) == o);
  endfunction

  // ==========================================
  // command, page buffer and write cycle
  spw_state_t st_ff, nxt_st;
  spw_cmd_t cmd_ff, nxt_cmd;
  spw_stat_t stat_ff, nxt_stat;
  logic [`SPW_AW-1:0] addr_ff, nxt_addr;
  logic [`SPW_PW-1:0] walk_ff, nxt_walk;
  logic [7:0] buf_ff [`SPW_PAGE];
  logic [7:0] nxt_buf [`SPW_PAGE];
  logic [`SPW_PAGE-1:0] mark_ff, nxt_mark;
  logic ok_ff, nxt_ok;
  logic [7:0] swr_ff, nxt_swr;
  logic swr_have_ff, nxt_swr_have;
  logic swr_pend_ff, nxt_swr_pend;
  logic [`SPW_WC_W-1:0] tmr_ff, nxt_tmr;
  logic fifo_in_valid;
  logic fifo_in_ready;
  spw_arr_t fifo_in;
  logic fifo_out_valid;
  logic fifo_out_ready;
  spw_arr_t fifo_out;
  logic arr_we_ff, nxt_arr_we;
  spw_arr_t arr_word_ff, nxt_arr_word;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_cmd = cmd_ff;
    nxt_stat = stat_ff;
    nxt_addr = addr_ff;
    nxt_walk = walk_ff;
    nxt_buf = buf_ff;
    nxt_mark = mark_ff;
    nxt_ok = ok_ff;
    nxt_swr = swr_ff;
    nxt_swr_have = swr_have_ff;
    nxt_swr_pend = swr_pend_ff;
    nxt_tmr = tmr_ff;
    hw_prot = stat_ff.arm & ~wp_s2_ff;
    fifo_in_valid = 1'b0;
    fifo_in.addr = {addr_ff[`SPW_AW-1:`SPW_PW], walk_ff};
    fifo_in.data = buf_ff[walk_ff];
    case (st_ff)
      SPW_IDLE:
      begin
        if (frm_start)
        begin
          nxt_st = SPW_OPC;
          nxt_cmd = SPW_C_NONE;
        end
      end
      SPW_OPC:
      begin
        if (frm_end)
        begin
          nxt_st = SPW_IDLE;
        end
        else if (byte_evt)
        begin
          nxt_st = SPW_SKIP;
          if (is_opc(rx_ff, `SPW_OPC_WRITE))
          begin
            nxt_st = SPW_AHI;
          end
          else if (is_opc(rx_ff, `SPW_OPC_STWR))
          begin
            nxt_st = SPW_STWR;
            nxt_swr_have = 1'b0;
          end
          else if (is_opc(rx_ff, `SPW_OPC_SETL))
          begin
            nxt_cmd = SPW_C_SETL;
          end
          else if (is_opc(rx_ff, `SPW_OPC_CLRL))
          begin
            nxt_cmd = SPW_C_CLRL;
          end
        end
      end
      SPW_AHI:
      begin
        if (frm_end)
        begin
          nxt_st = SPW_IDLE;
        end
        else if (byte_evt)
        begin
          // top three address bits fall away here
          nxt_addr = {rx_ff[`SPW_AW-9:0], addr_ff[7:0]};
          nxt_st = SPW_ALO;
        end
      end
      SPW_ALO:
      begin
        if (frm_end)
        begin
          nxt_st = SPW_IDLE;
        end
        else if (byte_evt)
        begin
          nxt_addr = {addr_ff[`SPW_AW-1:8], rx_ff};
          nxt_mark = '0;
          // guard edges are page aligned, so one check covers the page
          // the arm bit and pin play no part here
          nxt_ok = stat_ff.latch &
                   ~in_guard(stat_ff.bg, {addr_ff[`SPW_AW-1:8], rx_ff});
          nxt_st = SPW_DATA;
        end
      end
      SPW_DATA:
      begin
        if (frm_end)
        begin
          // a frame end mid-byte still launches the write; the partial byte is dropped
          if (ok_ff && (mark_ff != '0))
          begin
            nxt_st = SPW_LOAD;
            nxt_walk = '0;
            nxt_stat.busy = 1'b1;
          end
          else
          begin
            nxt_st = SPW_IDLE; // no cycle, array untouched
          end
        end
        else if (byte_evt)
        begin
          // later bytes overwrite earlier ones at the same slot
          nxt_buf[addr_ff[`SPW_PW-1:0]] = rx_ff;
          nxt_mark[addr_ff[`SPW_PW-1:0]] = 1'b1;
          // pointer wraps inside the page only
          nxt_addr[`SPW_PW-1:0] = addr_ff[`SPW_PW-1:0] + 1'b1;
        end
      end
      SPW_STWR:
      begin
        if (frm_end)
        begin
          nxt_st = SPW_IDLE;
          // status fields need latch 1 and protection off
          if (swr_have_ff && stat_ff.latch && !hw_prot)
          begin
            nxt_st = SPW_WAIT;
            nxt_tmr = '0;
            nxt_swr_pend = 1'b1;
            nxt_stat.busy = 1'b1;
          end
        end
        else if (byte_evt && !swr_have_ff)
        begin
          nxt_swr = rx_ff;
          nxt_swr_have = 1'b1;
        end
      end
      SPW_SKIP:
      begin
        if (frm_end)
        begin
          nxt_st = SPW_IDLE;
          if (cmd_ff == SPW_C_SETL)
          begin
            nxt_stat.latch = 1'b1;
          end
          else if (cmd_ff == SPW_C_CLRL)
          begin
            nxt_stat.latch = 1'b0;
          end
        end
      end
      SPW_LOAD:
      begin
        // unmarked slots are skipped; a full fifo stalls the walk
        fifo_in_valid = mark_ff[walk_ff];
        if (!mark_ff[walk_ff] || fifo_in_ready)
        begin
          nxt_walk = walk_ff + 1'b1;
          if (walk_ff == `SPW_PG_LAST)
          begin
            nxt_st = SPW_DRAIN;
          end
        end
      end
      SPW_DRAIN:
      begin
        if (!fifo_out_valid && !arr_we_ff)
        begin
          nxt_st = SPW_WAIT;
          nxt_tmr = '0;
        end
      end
      SPW_WAIT:
      begin
        // frames during the cycle are ignored, status reads included;
        // this block has no read path, only the busy flag on ready_n
        nxt_tmr = tmr_ff + 1'b1;
        if (tmr_ff == WC_CYC[`SPW_WC_W-1:0] - 1'b1)
        begin
          nxt_st = SPW_IDLE;
          nxt_stat.busy = 1'b0;
          nxt_stat.latch = 1'b0;
          nxt_swr_pend = 1'b0;
          if (swr_pend_ff)
          begin
            nxt_stat.arm = swr_ff[`SPW_SB_ARM];
            nxt_stat.bg = {swr_ff[`SPW_SB_BG_HI], swr_ff[`SPW_SB_BG_LO]};
          end
        end
      end
      default:
      begin
        nxt_st = SPW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= SPW_IDLE;
      cmd_ff <= SPW_C_NONE;
      stat_ff <= '0;
      addr_ff <= '0;
      walk_ff <= '0;
      buf_ff <= '{default: 8'h00};
      mark_ff <= '0;
      ok_ff <= 1'b0;
      swr_ff <= '0;
      swr_have_ff <= 1'b0;
      swr_pend_ff <= 1'b0;
      tmr_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
      cmd_ff <= nxt_cmd;
      stat_ff <= nxt_stat;
      addr_ff <= nxt_addr;
      walk_ff <= nxt_walk;
      buf_ff <= nxt_buf;
      mark_ff <= nxt_mark;
      ok_ff <= nxt_ok;
      swr_ff <= nxt_swr;
      swr_have_ff <= nxt_swr_have;
      swr_pend_ff <= nxt_swr_pend;
      tmr_ff <= nxt_tmr;
    end
  end

  // ==========================================
  // array write queue; arr_ready back-pressure leaves at most 31 words in it, so it never fills
  spw_fifo #(
    .WIDTH($bits(spw_arr_t)),
    .DEPTH(`SPW_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out)
  );

  // ==========================================
  // registered array port
  always_comb
  begin
    fifo_out_ready = ~arr_we_ff | arr_ready;
    nxt_arr_we = arr_we_ff;
    nxt_arr_word = arr_word_ff;
    if (fifo_out_ready)
    begin
      nxt_arr_we = fifo_out_valid;
      nxt_arr_word = fifo_out_valid ? fifo_out : arr_word_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arr_we_ff <= 1'b0;
      arr_word_ff <= '0;
    end
    else
    begin
      arr_we_ff <= nxt_arr_we;
      arr_word_ff <= nxt_arr_word;
    end
  end

  assign arr_we = arr_we_ff;
  assign arr_word = arr_word_ff;
  assign ready_n = stat_ff.busy;
  assign write_latch = stat_ff.latch;
  assign hw_guard_arm_bit = stat_ff.arm;
  assign block_guard_bit_hi = stat_ff.bg[1];
  assign block_guard_bit_lo = stat_ff.bg[0];

endmodule

/* File: dv/spw_sva.sv */
// port checker for the page-write block
// assumes it is bound onto spw_top
`timescale 1ns/100ps

module spw_sva #(
  parameter int WC_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic arr_ready,
  input wire logic arr_we,
  input wire spw_pkg::spw_arr_t arr_word,
  input wire logic ready_n,
  input wire logic write_latch,
  input wire logic hw_guard_arm_bit,
  input wire logic block_guard_bit_hi,
  input wire logic block_guard_bit_lo
);
  import spw_pkg::*;
  logic [1:0] bg;
  logic [12:0] a;
  assign bg = {block_guard_bit_hi, block_guard_bit_lo};
  assign a = arr_word.addr;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // array port steps
  sequence took_s;
    arr_we && arr_ready;
  endsequence
  sequence stall_s;
    arr_we && !arr_ready;
  endsequence
  hold_word_a: assert property (stall_s |=> arr_we && $stable(arr_word))
    else $error("array word changed while stalled");
  slot_order_a: assert property (took_s ##1 arr_we |->
    a[12:5] == $past(a[12:5]) && a[4:0] > $past(a[4:0]))
    else $error("array words leave the page or repeat a slot");
  busy_write_a: assert property (arr_we |-> ready_n)
    else $error("array write outside a write cycle");
  guard_area_a: assert property (arr_we |-> !(bg == 2'b11 ||
    (bg == 2'b10 && a[12]) || (bg == 2'b01 && a[12:11] == 2'b11)))
    else $error("array write inside guarded block");
  // ==========================================
  // latch and status
  latch_end_a: assert property ($fell(ready_n) |-> !write_latch)
    else $error("latch still set after write cycle");
  start_latch_a: assert property ($rose(ready_n) |-> write_latch)
    else $error("write cycle started without latch");
  field_time_a: assert property (!$stable({hw_guard_arm_bit, bg})
    |-> $fell(ready_n))
    else $error("guard fields changed outside cycle end");
  latch_idle_a: assert property ($rose(write_latch)
    |-> !ready_n && !$past(ready_n))
    else $error("latch set while busy");
  busy_bound_a: assert property ($rose(ready_n) |-> ##[1:1000] !ready_n)
    else $error("write cycle never ends");
endmodule

/* File: dv/spw_host.sv */
// spi host model: mode 0, msb first, sck only inside frames
// assumes the caller spaces frames through its own idle waits
`timescale 1ns/100ps

module spw_host (
  output logic sck,
  output logic cs_n,
  output logic si
);
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // ==========================================
  // one frame, 80 ns sck, odd offset keeps phase unrelated
  task automatic frame(input logic [7:0] b[$]);
    #13 cs_n = 1'b0;
    #40;
    foreach (b[i])
      for (int k = 7; k >= 0; k--)
      begin
        si = b[i][k];
        #40 sck = 1'b1;
        #40 sck = 1'b0;
      end
    #40 cs_n = 1'b1;
    si = ~si;
    #200;
  endtask
endmodule

/* File: dv/spw_top_bench.sv */
// self-checking bench for spw_top with host model and stalling array
// assumes spw_pkg compiled first and short write cycle
`timescale 1ns/100ps

module spw_top_bench;
  import spw_pkg::*;
  localparam int WC = 20;
  logic clk_sys, rst_n, wp_n, arr_ready, arr_we, ready_n, write_latch;
  logic arm, bg_hi, bg_lo, sck, cs_n, si;
  spw_arr_t arr_word;
  spw_arr_t exp_q[$];
  int fail_count = 0;
  int checks_done = 0;
  integer seed = 59;
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  spw_host host (.sck(sck), .cs_n(cs_n), .si(si));
  spw_top #(.WC_CYC(WC)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .arr_ready(arr_ready), .arr_we(arr_we), .arr_word(arr_word),
    .ready_n(ready_n), .write_latch(write_latch),
    .hw_guard_arm_bit(arm), .block_guard_bit_hi(bg_hi),
    .block_guard_bit_lo(bg_lo));
  // ==========================================
  // checking
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // random stalls keep the array side honest
  always @(posedge clk_sys)
    #2 arr_ready = 1'($random(seed));
  // sampled mid-cycle, where the coming edge's handshake is settled
  always @(negedge clk_sys)
    if (arr_we === 1'b1 && arr_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("stray word", 32'(arr_word), 32'h0000_0000);
      else
        check("word", 32'(arr_word), 32'(exp_q.pop_front()));
    end
  // ==========================================
  // stimulus helpers
  task automatic idle();
    int n = 0;
    repeat (12) @(posedge clk_sys);
    while (ready_n !== 1'b0 && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 3000)
    begin
      check("busy timeout", 32'h0000_0001, 32'h0000_0000);
      report_and_stop();
    end
  endtask
  task automatic send(input logic [7:0] b[$]);
    host.frame(b);
    idle();
  endtask
  task automatic stat(logic [2:0] e);
    check("fields", 32'({arm, bg_hi, bg_lo}), 32'(e));
  endtask
  task automatic wp(logic v);
    @(posedge clk_sys);
    #2 wp_n = v;
  endtask
  // slots come back in slot order, last byte per slot wins
  task automatic page_write(logic [7:0] op, logic [15:0] a, int n, bit ok);
    logic [7:0] d[$];
    logic [7:0] img[32];
    bit hit[32];
    d = {op, a[15:8], a[7:0]};
    for (int i = 0; i < n; i++)
    begin
      d.push_back(8'($random(seed)));
      img[(a[4:0] + i) % 32] = d[$];
      hit[(a[4:0] + i) % 32] = 1'b1;
    end
    for (int s = 0; s < 32; s++)
      if (ok && hit[s])
        exp_q.push_back({a[12:5], 5'(s), img[s]});
    send(d);
    if (ok)
      check("latch after write", 32'(write_latch), 32'h0000_0000);
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    arr_ready = 1'b0;
    repeat (6) @(posedge clk_sys);
    #2 rst_n = 1'b1;
    @(posedge clk_sys);
    stat(3'b000);
    check("latch reset", 32'(write_latch), 32'h0000_0000);
    page_write(8'h02, 16'h0040, 3, 1'b0);
    send({8'h01, 8'h0c});
    stat(3'b000);
    $display("no-latch test done");
    send({8'h06});
    check("latch set", 32'(write_latch), 32'h0000_0001);
    page_write(8'h0a, 16'he01e, 34, 1'b1);
    send({8'h06});
    page_write(8'h02, 16'h0123, 1, 1'b1);
    // a set-latch frame inside the write cycle must be ignored
    send({8'h06});
    exp_q.push_back({8'h09, 5'h00, 8'h5a});
    host.frame({8'h02, 8'h01, 8'h20, 8'h5a});
    host.frame({8'h06});
    idle();
    check("latch while busy", 32'(write_latch), 32'h0000_0000);
    $display("page test done");
    for (int c = 0; c < 4; c++)
    begin
      send({8'h06});
      send({8'h01, 8'({c[1:0], 2'b00})});
      stat({1'b0, c[1:0]});
      for (int k = 0; k < 4; k++)
      begin
        send({8'h06});
        // code 11 guards the whole array, not just the top quarter
        page_write(8'h02, 16'(k * 16'h0800 + 16'h07e0), 2,
          (c != 3) &&
          ((k * 16'h0800 + 16'h07e0) < (16'h2000 - c * 16'h0800)));
      end
    end
    $display("guard test done");
    send({8'h06});
    send({8'h01, 8'h80});
    stat(3'b100);
    wp(1'b0);
    send({8'h06});
    send({8'h01, 8'h0c});
    stat(3'b100);
    send({8'h06});
    page_write(8'h02, 16'h0040, 2, 1'b1);
    wp(1'b1);
    send({8'h06});
    send({8'h01, 8'h00});
    stat(3'b000);
    $display("hardware guard test done");
    send({8'h06});
    send({8'h04});
    check("latch cleared", 32'(write_latch), 32'h0000_0000);
    send({8'h01, 8'h0c});
    stat(3'b000);
    repeat (20) @(posedge clk_sys);
    check("words left", 32'(exp_q.size()), 32'h0000_0000);
    $display("clear latch test done");
    report_and_stop();
  end
endmodule

bind spw_top spw_sva #(.WC_CYC(WC_CYC)) chk (.clk_sys(clk_sys),
  .rst_n(rst_n), .arr_ready(arr_ready), .arr_we(arr_we),
  .arr_word(arr_word), .ready_n(ready_n), .write_latch(write_latch),
  .hw_guard_arm_bit(hw_guard_arm_bit),
  .block_guard_bit_hi(block_guard_bit_hi),
  .block_guard_bit_lo(block_guard_bit_lo));
